// *** acd_chopper.v ***
// PWM chopper for one H-bridge with adaptive decay and APB registers
//
// Operation
// - Dynamic share recomputed once per PWM cycle
// - Overshoot raises fast share next cycle
// - Long drive lowers fast share in the same cycle
// - Falling microstep forces pure fast decay in dynamic mode
// - Ripple mode: slow decay until valley
// - Ripple band 25 mA plus 1/2/4/6 percent
// - Off period except ripple mode: any partial fast share, then a full off time of slow
// - Off time 9/19/27/35 us, strap same
// - Off time changes accepted while running
// - Comparator masked for blanking after drive
// - Strap mode blanking fixed 1.5 us
// - Register blanking 1/1.5/2/2.5 us
// - Extra 0.5 us deglitch near trip
// - Decay field 110 dynamic, 111 ripple
// - Mixed off: fast share then slow
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acd_map.vh"
module acd_chopper #(
  parameter CW = 12,
  parameter STEPS = `ACD_SHARE_STEPS,
  parameter [CW-1:0] LONG_DRIVE = 12'h0C8
) (
  input wire i_clk, // Core clock
  input wire i_reset, // Synchronous reset, high
  input wire i_psel, // APB select
  input wire i_penable, // APB enable
  input wire i_pwrite, // APB direction
  input wire [11:0] i_paddr, // APB byte address
  input wire [31:0] i_pwdata, // APB write data
  output wire o_pready, // APB ready
  output reg [31:0] o_prdata, // APB read data
  output wire o_pslverr, // APB error
  input wire i_enable, // Bridge run enable
  input wire i_step_falling, // Pulse: target current lowered
  input wire i_cmp_upper, // Async: current above chop_upper_threshold
  input wire i_cmp_lower, // Async: current below chop_lower_threshold
  input wire i_cmp_near, // Async: current near chop_upper_threshold
  input wire [1:0] i_strap_off, // Async: decoded off-time strap level
  input wire [1:0] i_strap_decay, // Async: decoded decay strap code
  output reg o_drive, // Bridge driving
  output reg o_fast, // Bridge in fast decay
  output reg o_slow, // Bridge in slow decay
  output reg [1:0] o_ripple_band_sel // Ripple code to valley DAC
);
  localparam S_DRIVE = 3'b001;
  localparam S_FAST = 3'b010;
  localparam S_SLOW = 3'b100;
  localparam SW = $clog2(STEPS + 1);

  // Rounded-up cycle counts from ns figures
  function [CW-1:0] ns2cyc;
    input integer ns;
    integer t;
    begin
      t = (ns * `ACD_CLK_MHZ + 999) / 1000;
      ns2cyc = t[CW-1:0];
    end
  endfunction

  // Fixed mixed-decay fast share, in tenths of the off time
  function [CW-1:0] mix_len;
    input [CW-1:0] off;
    input integer tenths;
    integer t;
    begin
      t = (off * tenths) / 10;
      mix_len = t[CW-1:0];
    end
  endfunction

  wire [4:0] cmp_s;
  wire [1:0] strap_off_s;
  wire [1:0] strap_decay_s;
  acd_sync #(.W(9)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_cmp_upper, i_cmp_lower, i_cmp_near, i_strap_off, i_strap_decay, 2'b00}),
    .o_sync({cmp_s[0], cmp_s[1], cmp_s[2], strap_off_s, strap_decay_s, cmp_s[4:3]})
  );
  wire up_s = cmp_s[0];
  wire low_s = cmp_s[1];
  wire near_s = cmp_s[2];

  reg [31:0] ctrl_ff;
  wire hw_mode = ctrl_ff[`ACD_CTRL_HWIF_BIT];
  reg [2:0] strap_dec;
  always @* begin
    case (strap_decay_s)
      2'h0: strap_dec = `ACD_DECAY_SLOW;
      2'h1: strap_dec = `ACD_DECAY_MIX30;
      2'h2: strap_dec = `ACD_DECAY_DYN;
      default: strap_dec = `ACD_DECAY_RIPPLE;
    endcase
  end
  wire [2:0] decay = hw_mode ? strap_dec : ctrl_ff[`ACD_CTRL_DECAY_LSB +: 3];
  wire [1:0] off_sel = hw_mode ? strap_off_s : ctrl_ff[`ACD_CTRL_OFF_LSB +: 2];
  wire [1:0] mask_sel = ctrl_ff[`ACD_CTRL_MASK_LSB +: 2];
  wire [1:0] ripple_sel = hw_mode ? strap_off_s : ctrl_ff[`ACD_CTRL_RIPPLE_LSB +: 2];

  reg [CW-1:0] off_cyc;
  always @* begin
    case (off_sel)
      2'h0: off_cyc = ns2cyc(`ACD_OFF_NS0);
      2'h1: off_cyc = ns2cyc(`ACD_OFF_NS1);
      2'h2: off_cyc = ns2cyc(`ACD_OFF_NS2);
      default: off_cyc = ns2cyc(`ACD_OFF_NS3);
    endcase
  end
  reg [CW-1:0] mask_cyc;
  always @* begin
    if (hw_mode) begin
      mask_cyc = ns2cyc(`ACD_MASK_NS1);
    end else begin
      case (mask_sel)
        2'h0: mask_cyc = ns2cyc(`ACD_MASK_NS0);
        2'h1: mask_cyc = ns2cyc(`ACD_MASK_NS1);
        2'h2: mask_cyc = ns2cyc(`ACD_MASK_NS2);
        default: mask_cyc = ns2cyc(`ACD_MASK_NS3);
      endcase
    end
  end
  wire [CW-1:0] degl_cyc = ns2cyc(`ACD_DEGLITCH_NS);

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [CW-1:0] cnt_ff;
  reg [CW-1:0] nxt_cnt;
  reg [CW-1:0] degl_ff;
  reg [SW-1:0] share_ff;
  reg [SW-1:0] nxt_share;
  reg [CW-1:0] fast_len_ff;
  reg [CW-1:0] nxt_fast_len;
  reg over_ff;
  reg falling_ff;
  reg [15:0] cycles_ff;

  // Comparator trip after blanking, plus deglitch while near the trip level
  wire masked = (cnt_ff < mask_cyc);
  wire trip = up_s && !masked && (!near_s || degl_ff >= degl_cyc);
  wire long_drive = (cnt_ff >= LONG_DRIVE);

  function [CW-1:0] share_len;
    input [CW-1:0] off;
    input [SW-1:0] sh;
    integer t;
    begin
      t = (off * sh) / STEPS;
      share_len = t[CW-1:0];
    end
  endfunction

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_share = share_ff;
    nxt_fast_len = fast_len_ff;
    case (state_ff)
      S_DRIVE: begin
        if (trip) begin
          nxt_cnt = {CW{1'b0}};
          if (decay == `ACD_DECAY_RIPPLE) begin
            nxt_state = S_SLOW;
          end else begin
            // Once per cycle, using last cycle's overshoot and this drive's length
            if (decay == `ACD_DECAY_DYN) begin
              // Overshoot wins: at full share it holds rather than falling back
              if (over_ff) begin
                if (share_ff < STEPS) begin
                  nxt_share = share_ff + 1'b1;
                end
              end else if (long_drive && share_ff != 0) begin
                nxt_share = share_ff - 1'b1;
              end
            end
            case (decay)
              `ACD_DECAY_MIX30: nxt_fast_len = mix_len(off_cyc, 3);
              `ACD_DECAY_MIX60: nxt_fast_len = mix_len(off_cyc, 6);
              `ACD_DECAY_DYN: nxt_fast_len = falling_ff ? off_cyc : share_len(off_cyc, nxt_share);
              default: nxt_fast_len = {CW{1'b0}};
            endcase
            nxt_state = (nxt_fast_len != 0) ? S_FAST : S_SLOW;
          end
        end
      end
      S_FAST: begin
        // Live off_cyc lets a new off time take effect mid-run
        if (cnt_ff + 1'b1 >= fast_len_ff) begin
          nxt_state = (fast_len_ff >= off_cyc) ? S_DRIVE : S_SLOW;
        end
      end
      default: begin
        if (decay == `ACD_DECAY_RIPPLE ? low_s : (cnt_ff + 1'b1 >= off_cyc)) begin
          nxt_state = S_DRIVE;
          nxt_cnt = {CW{1'b0}};
        end
      end
    endcase
    if (nxt_state != state_ff) begin
      nxt_cnt = {CW{1'b0}};
    end
  end

  always @(posedge i_clk) begin
    if (i_reset || !i_enable) begin
      state_ff <= S_DRIVE;
      cnt_ff <= {CW{1'b0}};
      degl_ff <= {CW{1'b0}};
      fast_len_ff <= {CW{1'b0}};
      over_ff <= 1'b0;
      cycles_ff <= 16'h0000;
      if (i_reset) begin
        share_ff <= {SW{1'b0}};
        falling_ff <= 1'b0;
      end
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (cnt_ff == {CW{1'b1}}) ? cnt_ff : nxt_cnt;
      degl_ff <= (up_s && near_s) ? degl_ff + 1'b1 : {CW{1'b0}};
      share_ff <= nxt_share;
      fast_len_ff <= nxt_fast_len;
      // Overshoot: comparator still high when the off period ends
      if (state_ff == S_DRIVE && nxt_state != S_DRIVE) begin
        over_ff <= 1'b0;
      end else if (state_ff != S_DRIVE && nxt_state == S_DRIVE) begin
        over_ff <= up_s;
        cycles_ff <= cycles_ff + 1'b1;
      end
      // A falling step stands until the next fast decision consumes it
      if (i_step_falling) begin
        falling_ff <= 1'b1;
      end else if (state_ff == S_DRIVE && trip && decay == `ACD_DECAY_DYN) begin
        falling_ff <= 1'b0;
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      o_drive <= 1'b0;
      o_fast <= 1'b0;
      o_slow <= 1'b0;
      o_ripple_band_sel <= 2'h0;
    end else begin
      o_drive <= i_enable && nxt_state == S_DRIVE;
      o_fast <= i_enable && nxt_state == S_FAST;
      o_slow <= i_enable && nxt_state == S_SLOW;
      o_ripple_band_sel <= ripple_sel;
    end
  end

  // APB: zero-wait slave, unmapped addresses answer with an error
  wire acc = i_psel && i_penable;
  wire hit_ctrl = (i_paddr == `ACD_ADDR_CTRL);
  wire hit_stat = (i_paddr == `ACD_ADDR_STAT);
  wire hit_share = (i_paddr == `ACD_ADDR_SHARE);
  wire mapped = hit_ctrl || hit_stat || hit_share;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;

  always @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_ff <= `ACD_CTRL_RESET;
    end else if (acc && i_pwrite && hit_ctrl) begin
      ctrl_ff <= {21'h0, i_pwdata[10:0]};
    end
  end

  always @* begin
    o_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      o_prdata = ctrl_ff;
    end else if (hit_stat) begin
      o_prdata = {cycles_ff, 8'h00, 2'h0, falling_ff, over_ff, 1'b0, state_ff};
    end else if (hit_share) begin
      o_prdata = {{(32 - SW){1'b0}}, share_ff};
    end
  end
endmodule // acd_chopper
`default_nettype wire

// *** acd_chopper_asserts.sv ***
// Port-level checks for the chopper
`timescale 1ns/1ps
`default_nettype none
module acd_chopper_asserts (
  input wire logic i_clk, // clock
  input wire logic i_reset, // reset
  input wire logic i_psel, // apb
  input wire logic i_penable, // apb
  input wire logic i_pwrite, // apb
  input wire logic [11:0] i_paddr, // apb
  input wire logic [31:0] i_pwdata, // apb
  input wire logic o_pready, // apb
  input wire logic [31:0] o_prdata, // apb
  input wire logic o_pslverr, // apb
  input wire logic i_enable, // run
  input wire logic i_cmp_upper, // trip
  input wire logic i_cmp_lower, // valley
  input wire logic i_cmp_near, // near trip
  input wire logic o_drive, // drive
  input wire logic o_fast, // fast decay
  input wire logic o_slow // slow decay
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic acc, rip_ff;
  logic [2:0] mode_ff;
  logic [8:0] run_ff, up_ff;
  assign acc = i_psel && i_penable;
  // Mode is latched during drive so a rewrite in mid-off is judged from the next cycle
  always @(posedge i_clk) begin
    if (i_reset) begin
      mode_ff <= 3'h7;
      rip_ff <= 1'b0;
      run_ff <= 9'h000;
      up_ff <= 9'h000;
    end else begin
      if (acc && i_pwrite && i_paddr == 12'h000) mode_ff <= i_pwdata[10] ? 3'h0 : i_pwdata[2:0];
      if (o_drive) rip_ff <= mode_ff == 3'h7;
      run_ff <= o_drive ? run_ff + 9'h001 : 9'h000;
      up_ff <= i_cmp_upper ? up_ff + {8'h00, up_ff != 9'h1FF} : 9'h000;
    end
  end
  sequence drive_end_s;
    $fell(o_drive) && $past(i_enable) && !$past(i_reset);
  endsequence
  err_map_a: assert property (acc && i_paddr > 12'h008 |-> o_pslverr && o_pready && (i_pwrite || o_prdata == 32'h0))
    else $error("unmapped access not refused");
  idle_off_a: assert property (!i_enable && !$past(i_enable) && !$past(i_reset) |-> !(o_drive || o_fast || o_slow))
    else $error("bridge active while disabled");
  one_state_a: assert property (i_enable && $past(i_enable) && !$past(i_reset) |-> $onehot({o_drive, o_fast, o_slow}))
    else $error("bridge state not one-hot");
  blank_min_a: assert property (drive_end_s |-> run_ff >= 9'h064)
    else $error("drive shorter than blanking");
  trip_cause_a: assert property (drive_end_s |-> $past(i_cmp_upper, 3))
    else $error("drive ended without trip");
  deglitch_a: assert property (drive_end_s ##0 $past(i_cmp_near, 4) |-> up_ff >= 9'h030)
    else $error("near-trip deglitch skipped");
  fast_entry_a: assert property ($rose(o_fast) |-> $past(o_drive))
    else $error("fast decay not entered from drive");
  ripple_slow_a: assert property ($rose(o_fast) |-> !rip_ff)
    else $error("fast decay in ripple mode");
  valley_a: assert property ($fell(o_slow) && rip_ff && $past(i_enable) |-> $past(i_cmp_lower, 3))
    else $error("slow decay left above valley");
endmodule // acd_chopper_asserts
`default_nettype wire

// *** acd_coil_model.sv ***
// Coil current and comparator model facing the chopper
`timescale 1ns/1ps
`default_nettype none
module acd_coil_model (
  input wire logic i_clk, // clock
  input wire logic i_drive, // bridge driving
  input wire logic i_fast, // fast decay
  input wire logic [9:0] i_trip, // trip level
  input wire logic i_stuck, // hold comparator tripped
  output logic o_upper, // above trip
  output logic o_lower // below valley
);
  logic [9:0] cur = 10'h000;
  // Fast decay drains four times quicker so the fast share shows in the current
  always @(posedge i_clk) begin
    if (i_drive) begin
      cur <= cur + 10'h001;
    end else if (i_fast) begin
      cur <= cur > 10'h004 ? cur - 10'h004 : 10'h000;
    end else if (cur != 10'h000) begin
      cur <= cur - 10'h001;
    end
  end
  assign o_upper = i_stuck || cur >= i_trip;
  assign o_lower = cur + 10'h010 < i_trip;
endmodule // acd_coil_model
`default_nettype wire

// *** acd_map.vh ***
// Constants for the adaptive chopper decay timing block
`ifndef ACD_MAP_VH
`define ACD_MAP_VH
`define ACD_CLK_MHZ 100
`define ACD_ADDR_CTRL 12'h000
`define ACD_ADDR_STAT 12'h004
`define ACD_ADDR_SHARE 12'h008
`define ACD_CTRL_DECAY_LSB 0
`define ACD_CTRL_OFF_LSB 4
`define ACD_CTRL_MASK_LSB 6
`define ACD_CTRL_RIPPLE_LSB 8
`define ACD_CTRL_HWIF_BIT 10
`define ACD_CTRL_RESET 32'h0000_0057
`define ACD_DECAY_SLOW 3'h0
`define ACD_DECAY_MIX30 3'h4
`define ACD_DECAY_MIX60 3'h5
`define ACD_DECAY_DYN 3'h6
`define ACD_DECAY_RIPPLE 3'h7
`define ACD_OFF_NS0 9000
`define ACD_OFF_NS1 19000
`define ACD_OFF_NS2 27000
`define ACD_OFF_NS3 35000
`define ACD_MASK_NS0 1000
`define ACD_MASK_NS1 1500
`define ACD_MASK_NS2 2000
`define ACD_MASK_NS3 2500
`define ACD_DEGLITCH_NS 500
`define ACD_RIPPLE_BASE_MA 25
`define ACD_RIPPLE_PCT0 1
`define ACD_RIPPLE_PCT1 2
`define ACD_RIPPLE_PCT2 4
`define ACD_RIPPLE_PCT3 6
`define ACD_SHARE_STEPS 16
`endif

// *** acd_sync.v ***
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module acd_sync #(
  parameter W = 1
) (
  input wire i_clk, // Core clock
  input wire i_reset, // Synchronous reset
  input wire [W-1:0] i_async, // Asynchronous level
  output wire [W-1:0] o_sync // Synchronised level
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end
  assign o_sync = sync_ff;
endmodule // acd_sync
`default_nettype wire

// *** tb_acd_chopper.sv ***
// Self-checking bench: APB tasks, coil model and chopper timing tests
`timescale 1ns/1ps
`default_nettype none
module tb_acd_chopper;
  logic i_clk, i_reset, i_psel, i_penable, i_pwrite, i_enable, i_step_falling, i_cmp_near, stuck;
  logic o_pready, o_pslverr, o_drive, o_fast, o_slow, i_cmp_upper, i_cmp_lower;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, r;
  logic [1:0] i_strap_off, i_strap_decay, o_ripple_band_sel;
  logic [9:0] trip;
  logic [15:0] offt [4] = '{16'h0384, 16'h076C, 16'h0A8C, 16'h0DAC};
  logic [15:0] blank [4] = '{16'h0064, 16'h0096, 16'h00C8, 16'h00FA};
  int bad_count, check_count, dl, ol, fl, f1, i;
  acd_chopper i_acd_chopper (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_enable(i_enable), .i_step_falling(i_step_falling), .i_cmp_upper(i_cmp_upper),
    .i_cmp_lower(i_cmp_lower), .i_cmp_near(i_cmp_near), .i_strap_off(i_strap_off), .i_strap_decay(i_strap_decay),
    .o_drive(o_drive), .o_fast(o_fast), .o_slow(o_slow), .o_ripple_band_sel(o_ripple_band_sel));
  acd_coil_model i_acd_coil_model (.i_clk, .i_drive(o_drive), .i_fast(o_fast), .i_trip(trip), .i_stuck(stuck),
    .o_upper(i_cmp_upper), .o_lower(i_cmp_lower));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] inr(input int v, input int lo);
    return {31'h0, v >= lo - 2 && v <= lo + 6};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    r = o_prdata;
    chk({31'h0, o_pslverr}, {31'h0, e});
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1) begin
      bad_count++;
      end_sim();
    end else @(posedge i_clk);
  endtask
  // One call spans a drive phase and the off phase after it
  task automatic meas();
    int n, ph;
    ph = 0;
    dl = 0;
    ol = 0;
    fl = 0;
    for (n = 0; n < 9000 && ph < 3; n++) begin
      @(posedge i_clk);
      if (ph == 0 && o_drive === 1'b1) ph = 1;
      if (ph == 1 && o_drive !== 1'b1) ph = 2;
      if (ph == 2 && o_drive === 1'b1) ph = 3;
      dl += (ph == 1);
      ol += (ph == 2);
      fl += (ph == 2 && o_fast === 1'b1);
    end
    if (ph < 3) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic rd_share();
    repeat (20) @(posedge i_clk);
    apb(1'b0, 12'h008, 32'h0, 1'b0);
  endtask
  initial begin
    {i_psel, i_penable, i_pwrite, i_enable, i_step_falling, i_cmp_near, stuck} = 7'h00;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_strap_off = 2'h0;
    i_strap_decay = 2'h0;
    trip = 10'h020;
    i_reset = 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    apb(1'b0, 12'h000, 32'h0, 1'b0);
    chk(r, 32'h0000_0057);
    apb(1'b0, 12'h00C, 32'h0, 1'b1);
    chk(r, 32'h0);
    $display("reset values done");
    i_enable <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, {24'h0, i[1:0], i[1:0], 4'h0}, 1'b0);
      meas();
      meas();
      chk(ol, offt[i]);
      chk(inr(dl, blank[i]), 32'h1);
    end
    $display("off time and blanking done");
    apb(1'b1, 12'h000, 32'h0000_0400, 1'b0);
    meas();
    meas();
    chk(inr(dl, 150), 32'h1);
    chk(ol, offt[0]);
    for (i = 0; i < 4; i++) begin
      i_strap_off <= i[1:0];
      repeat (6) @(posedge i_clk);
      chk({30'h0, o_ripple_band_sel}, i);
    end
    $display("strap mode done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, {22'h0, i[1:0], 8'h37}, 1'b0);
      repeat (2) @(posedge i_clk);
      chk({30'h0, o_ripple_band_sel}, i);
    end
    meas();
    meas();
    chk(fl, 0);
    chk({31'h0, ol < 900}, 32'h1);
    $display("ripple mode done");
    apb(1'b1, 12'h000, 32'h0, 1'b0);
    trip <= 10'h0B4;
    i_cmp_near <= 1'b1;
    meas();
    meas();
    chk(inr(dl, 232), 32'h1);
    i_cmp_near <= 1'b0;
    $display("deglitch done");
    apb(1'b1, 12'h000, 32'h6, 1'b0);
    trip <= 10'h020;
    stuck <= 1'b1;
    meas();
    rd_share();
    f1 = r;
    meas();
    rd_share();
    chk(r, f1 < 16 ? f1 + 1 : 16);
    repeat (17) meas();
    rd_share();
    chk(r, 32'h10);
    meas();
    chk(fl, ol);
    stuck <= 1'b0;
    trip <= 10'h0FA;
    // The cycle already under way still carries the overshoot, so the share holds once
    meas();
    meas();
    rd_share();
    chk(r, 32'hF);
    repeat (17) meas();
    rd_share();
    chk(r, 32'h0);
    i_step_falling <= 1'b1;
    @(posedge i_clk);
    i_step_falling <= 1'b0;
    meas();
    f1 = fl;
    meas();
    chk(f1 + fl, offt[0]);
    $display("dynamic mode done");
    end_sim();
  end
endmodule // tb_acd_chopper
bind acd_chopper acd_chopper_asserts i_acd_chopper_asserts (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_enable(i_enable), .i_cmp_upper(i_cmp_upper),
  .i_cmp_lower(i_cmp_lower), .i_cmp_near(i_cmp_near), .o_drive(o_drive), .o_fast(o_fast), .o_slow(o_slow));
`default_nettype wire
